// ### rtl/sevirq_top.sv
// Card status-change flags, masks and interrupt routing for two sockets.
`timescale 1ns/1ps
`include "sevirq_regs.svh"
module sevirq_top
   import sevirq_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Register access.
   input  wire logic [11:0] regAddr,
   input  wire logic        regSocket,
   input  wire logic        regRead,
   input  wire logic        regWrite,
   input  wire logic [7:0]  regWdata,
   output logic      [7:0]  regRdata,
   // Card lines, one bit per socket.
   input  wire logic [1:0]  cardDetectA_n,
   input  wire logic [1:0]  cardDetectB_n,
   input  wire logic [1:0]  readyLine,
   input  wire logic [1:0]  batteryLowLine,
   input  wire logic [1:0]  cardEventLine_n,
   input  wire logic [1:0]  ringLine_n,
   // Socket configuration bits held elsewhere.
   input  wire logic [1:0]  ioCardSelect,
   input  wire logic [1:0]  ringFunctionEnable,
   input  wire logic [1:0]  eventPciRoute,
   input  wire logic [1:0]  clearOnWrite,
   input  wire logic        diagSocketEvent,
   // Routed interrupts.
   output logic      [15:0] legacyIrq,
   output logic             systemMgmtIrq,
   output logic             pciIrq
);
   sevirq_flags_type       eventFlags [2];
   logic [7:0]             routingMask [2];
   logic [1:0]             eventPending;
   logic [1:0]             flagsHit;
   logic [1:0]             maskHit;
   logic [1:0][15:0]       routeIrq;
   logic [1:0]             routeMgmt;
   logic [1:0]             routePci;
   logic [7:0]             next_regRdata;
   logic [15:0]            next_legacyIrq;
   logic                   next_systemMgmtIrq;
   logic                   next_pciIrq;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   for (genvar s = 0; s < 2; s++) begin : gSock
      localparam logic [11:0] FLAGS_OFS = (s == 0) ? `SEVIRQ_FLAGS_A : `SEVIRQ_FLAGS_B;
      localparam logic [11:0] MASK_OFS  = (s == 0) ? `SEVIRQ_MASK_A : `SEVIRQ_MASK_B;
      localparam logic        SOCK_ID   = (s == 0) ? 1'b0 : 1'b1;

      logic [`SEVIRQ_LINES-1:0] lineRaw;
      logic [`SEVIRQ_LINES-1:0] lineLevel;
      logic [`SEVIRQ_LINES-1:0] lineRise;
      logic [`SEVIRQ_LINES-1:0] lineFall;
      sevirq_flags_type         setFlags;
      sevirq_flags_type         clrFlags;
      sevirq_flags_type         next_eventFlags;
      logic [7:0]               next_routingMask;
      logic                     memCard;
      logic                     ringBit;
      logic [3:0]               sel;
      sevirq_route_type         kind;

      // Each socket answers at its local offset and in its own window.
      assign flagsHit[s] = (regAddr == FLAGS_OFS) ||
                           (regAddr == `SEVIRQ_FLAGS_WIN && regSocket == SOCK_ID);
      assign maskHit[s]  = (regAddr == MASK_OFS) ||
                           (regAddr == `SEVIRQ_MASK_WIN && regSocket == SOCK_ID);

      assign lineRaw = {ringLine_n[s], cardEventLine_n[s], batteryLowLine[s],
                        readyLine[s], cardDetectB_n[s], cardDetectA_n[s]};

      sevirq_line_sync uSync (
         .core_clk  (core_clk),
         .nrst      (nrst),
         .lineRaw   (lineRaw),
         .lineLevel (lineLevel),
         .lineRise  (lineRise),
         .lineFall  (lineFall)
      );

      assign memCard = !ioCardSelect[s];
      assign ringBit = ringFunctionEnable[s] && routingMask[s][`SEVIRQ_BIT_DEAD] &&
                       !lineLevel[`SEVIRQ_LN_RING];

      always_comb begin
         setFlags = '0;
         setFlags[`SEVIRQ_BIT_DETECT] = lineRise[`SEVIRQ_LN_DETA] | lineFall[`SEVIRQ_LN_DETA] |
                                        lineRise[`SEVIRQ_LN_DETB] | lineFall[`SEVIRQ_LN_DETB];
         setFlags[`SEVIRQ_BIT_READY]  = memCard & lineRise[`SEVIRQ_LN_READY];
         setFlags[`SEVIRQ_BIT_BATLOW] = memCard & lineRise[`SEVIRQ_LN_BATLOW];
         setFlags[`SEVIRQ_BIT_DEAD]   = lineFall[`SEVIRQ_LN_EVENT];
         setFlags = setFlags & routingMask[s][3:0];
         clrFlags = '0;
         if (regRead && flagsHit[s] && !clearOnWrite[s]) begin
            clrFlags = '1;
         end else if (regWrite && flagsHit[s] && clearOnWrite[s]) begin
            clrFlags = regWdata[3:0];
         end
         next_routingMask = routingMask[s];
         if (regWrite && maskHit[s]) begin
            next_routingMask = regWdata;
         end
         // A new event in the clearing cycle survives the clear.
         next_eventFlags = (eventFlags[s] & ~clrFlags) | setFlags;
         if (!memCard) begin
            next_eventFlags[`SEVIRQ_BIT_READY]  = 1'b0;
            next_eventFlags[`SEVIRQ_BIT_BATLOW] = 1'b0;
         end
         if (ringFunctionEnable[s]) begin
            next_eventFlags[`SEVIRQ_BIT_DEAD] = ringBit;
         end
         // Masking with the incoming enables drops a flag on the edge its enable clears.
         next_eventFlags = next_eventFlags & next_routingMask[3:0];
      end

      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            eventFlags[s]  <= '0;
            routingMask[s] <= `SEVIRQ_RESET_VAL;
         end else begin
            eventFlags[s]  <= next_eventFlags;
            routingMask[s] <= next_routingMask;
         end
      end

      assign eventPending[s] = |eventFlags[s];

      // The PCI route bit overrides the select field; the diagnostic bit routes to PCI only when the select field is zero.
      always_comb begin
         sel = routingMask[s][`SEVIRQ_SEL_MSB:`SEVIRQ_SEL_LSB];
         if (eventPciRoute[s] || (sel == `SEVIRQ_SEL_NONE && diagSocketEvent)) begin
            kind = SEVIRQ_ROUTE_PCI;
         end else if (sel == `SEVIRQ_SEL_NONE) begin
            kind = SEVIRQ_ROUTE_NONE;
         end else if (sel == `SEVIRQ_SEL_MGMT) begin
            kind = SEVIRQ_ROUTE_MGMT;
         end else begin
            kind = SEVIRQ_ROUTE_IRQ;
         end
         routeIrq[s]  = '0;
         routeMgmt[s] = 1'b0;
         routePci[s]  = 1'b0;
         unique case (kind)
            SEVIRQ_ROUTE_NONE: begin
               routePci[s] = 1'b0;
            end
            SEVIRQ_ROUTE_IRQ: begin
               routeIrq[s][sel] = eventPending[s];
            end
            SEVIRQ_ROUTE_MGMT: begin
               routeMgmt[s] = eventPending[s];
            end
            SEVIRQ_ROUTE_PCI: begin
               routePci[s] = eventPending[s];
            end
         endcase
      end

      maskZero_a: assert property (!routingMask[s][`SEVIRQ_BIT_READY]
         |-> !eventFlags[s][`SEVIRQ_BIT_READY])
         else $error("ready flag set while its source is masked");

      ioZero_a: assert property (ioCardSelect[s] && $past(ioCardSelect[s])
         |-> eventFlags[s][2:1] == 2'b00)
         else $error("I/O card shows ready or battery flag");

      readClear_a: assert property (regRead && flagsHit[s] && !clearOnWrite[s]
         && !ringFunctionEnable[s] && setFlags == '0 |=> eventFlags[s] == '0)
         else $error("read did not clear the flags");

      writeClear_a: assert property (regWrite && flagsHit[s] && clearOnWrite[s]
         && regWdata[2] && !setFlags[2] |=> !eventFlags[s][2])
         else $error("write of one did not clear ready flag");

      readKeeps_a: assert property (regRead && flagsHit[s] && clearOnWrite[s]
         && !ringFunctionEnable[s] && !regWrite |=> eventFlags[s] == $past(eventFlags[s])
         || $past(setFlags) != '0)
         else $error("read cleared flags in write-clear mode");

      detectSet_a: assert property (routingMask[s][3] && lineFall[`SEVIRQ_LN_DETB]
         ##1 routingMask[s][3] |-> eventFlags[s][3])
         else $error("detect change not flagged");

      readyRise_a: assert property (routingMask[s][2] && !ioCardSelect[s]
         && lineRise[`SEVIRQ_LN_READY] ##1 routingMask[s][2] && !ioCardSelect[s]
         |-> eventFlags[s][2])
         else $error("ready rise not flagged");

      flagHold_a: assert property (eventFlags[s][1] && routingMask[s][1]
         && !ioCardSelect[s] && !(regRead || regWrite) |=> eventFlags[s][1])
         else $error("battery flag dropped without a clear");

      ringShow_a: assert property (ringFunctionEnable[s] && routingMask[s][0]
         && !lineLevel[`SEVIRQ_LN_RING] ##1 ringFunctionEnable[s] && routingMask[s][0]
         |-> eventFlags[s][0])
         else $error("ring state not shown in bit 0");
   end

   always_comb begin
      next_regRdata = regRdata;
      if (regRead) begin
         next_regRdata = `SEVIRQ_RESET_VAL;
         for (int s = 0; s < 2; s++) begin
            if (flagsHit[s]) begin
               next_regRdata = {`SEVIRQ_RSVD_VAL, eventFlags[s]};
            end
            if (maskHit[s]) begin
               next_regRdata = routingMask[s];
            end
         end
      end
      next_legacyIrq     = routeIrq[0] | routeIrq[1];
      next_systemMgmtIrq = routeMgmt[0] | routeMgmt[1];
      next_pciIrq        = routePci[0] | routePci[1];
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         regRdata      <= `SEVIRQ_RESET_VAL;
         legacyIrq     <= '0;
         systemMgmtIrq <= 1'b0;
         pciIrq        <= 1'b0;
      end else begin
         regRdata      <= next_regRdata;
         legacyIrq     <= next_legacyIrq;
         systemMgmtIrq <= next_systemMgmtIrq;
         pciIrq        <= next_pciIrq;
      end
   end

   rsvdZero_a: assert property ($past(regRead) && $past(|flagsHit)
      |-> regRdata[7:4] == `SEVIRQ_RSVD_VAL)
      else $error("reserved status bits read nonzero");

   irqRoute_a: assert property (eventPending[0] && !eventPciRoute[0]
      && routingMask[0][7:4] > 4'h2 |=> legacyIrq[$past(routingMask[0][7:4])])
      else $error("legacy line for selected IRQ not raised");

   mgmtRoute_a: assert property (eventPending[1] && !eventPciRoute[1]
      && routingMask[1][7:4] == `SEVIRQ_SEL_MGMT |=> systemMgmtIrq)
      else $error("management interrupt not raised");

   diagPci_a: assert property (eventPending[0] && routingMask[0][7:4] == `SEVIRQ_SEL_NONE
      && diagSocketEvent |=> pciIrq)
      else $error("diagnostic routing to PCI failed");

   routeBit_a: assert property (eventPending[1] && eventPciRoute[1]
      |=> pciIrq && !legacyIrq[$past(routingMask[1][7:4])] || $past(eventPending[0]))
      else $error("PCI route bit did not override select");

   noRoute_a: assert property (routingMask[0][7:4] == `SEVIRQ_SEL_NONE && !diagSocketEvent
      && !eventPciRoute[0] && !eventPending[1] |=> !pciIrq && legacyIrq == '0
      && !systemMgmtIrq)
      else $error("interrupt raised with no routing");

   quiet_a: assert property (eventPending == 2'b00 [*2]
      |-> !pciIrq && !systemMgmtIrq && legacyIrq == '0)
      else $error("interrupt raised with nothing pending");

   legacyZero_a: assert property (!legacyIrq[0] && !legacyIrq[2])
      else $error("unused legacy line driven");

   pendCov_c: cover property (eventPending[0] ##1 legacyIrq != '0);
   mgmtCov_c: cover property (eventPending[1] ##1 systemMgmtIrq);
   pciCov_c: cover property (eventPending[0] && diagSocketEvent ##1 pciIrq);
   clrCov_c: cover property (eventPending[0] ##[1:20] !eventPending[0]);
endmodule : sevirq_top

// ### rtl/sevirq_regs.svh
// Offsets, field positions and reset values of the socket event interrupt block.
`ifndef SEVIRQ_REGS_SVH
`define SEVIRQ_REGS_SVH
`define SEVIRQ_FLAGS_A      12'h004
`define SEVIRQ_FLAGS_B      12'h044
`define SEVIRQ_FLAGS_WIN    12'h804
`define SEVIRQ_MASK_A       12'h005
`define SEVIRQ_MASK_B       12'h045
`define SEVIRQ_MASK_WIN     12'h805
`define SEVIRQ_RESET_VAL    8'h00
`define SEVIRQ_RSVD_VAL     4'h0
`define SEVIRQ_BIT_DETECT   3
`define SEVIRQ_BIT_READY    2
`define SEVIRQ_BIT_BATLOW   1
`define SEVIRQ_BIT_DEAD     0
`define SEVIRQ_SEL_MSB      7
`define SEVIRQ_SEL_LSB      4
`define SEVIRQ_SEL_NONE     4'h0
`define SEVIRQ_SEL_MGMT     4'h2
`define SEVIRQ_LINES        6
`define SEVIRQ_LN_DETA      0
`define SEVIRQ_LN_DETB      1
`define SEVIRQ_LN_READY     2
`define SEVIRQ_LN_BATLOW    3
`define SEVIRQ_LN_EVENT     4
`define SEVIRQ_LN_RING      5
`define SEVIRQ_LINE_IDLE    6'h33
`endif

// ### rtl/sevirq_pkg.sv
// Types shared by the socket event interrupt block.
package sevirq_pkg;
   typedef enum logic [3:0] {
      SEVIRQ_ROUTE_NONE = 4'b0001,
      SEVIRQ_ROUTE_IRQ  = 4'b0010,
      SEVIRQ_ROUTE_MGMT = 4'b0100,
      SEVIRQ_ROUTE_PCI  = 4'b1000
   } sevirq_route_type;
   typedef logic [3:0] sevirq_flags_type;
endpackage : sevirq_pkg

// ### rtl/sevirq_line_sync.sv
// Synchroniser and edge detector for the card lines of one socket.
`timescale 1ns/1ps
`include "sevirq_regs.svh"
module sevirq_line_sync
   import sevirq_pkg::*;
(
   // Clock and reset.
   input  wire logic                      core_clk,
   input  wire logic                      nrst,
   // Raw card lines.
   input  wire logic [`SEVIRQ_LINES-1:0]  lineRaw,
   // Synchronised levels and one-cycle edges.
   output logic      [`SEVIRQ_LINES-1:0]  lineLevel,
   output logic      [`SEVIRQ_LINES-1:0]  lineRise,
   output logic      [`SEVIRQ_LINES-1:0]  lineFall
);
   logic [`SEVIRQ_LINES-1:0] syncFirst;
   logic [`SEVIRQ_LINES-1:0] linePrev;
   logic [2:0]               warmUp;

   // Only the second stage and later are looked at by the edge logic.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         syncFirst <= `SEVIRQ_LINE_IDLE;
         lineLevel <= `SEVIRQ_LINE_IDLE;
         linePrev  <= `SEVIRQ_LINE_IDLE;
         warmUp    <= 3'h0;
      end else begin
         syncFirst <= lineRaw;
         lineLevel <= syncFirst;
         linePrev  <= lineLevel;
         warmUp    <= {warmUp[1:0], 1'b1};
      end
   end

   // Edges are ignored until the previous level holds a real sample, so a line
   // away from its idle level at release cannot fake an event after reset.
   assign lineRise = lineLevel & ~linePrev & {`SEVIRQ_LINES{warmUp[2]}};
   assign lineFall = ~lineLevel & linePrev & {`SEVIRQ_LINES{warmUp[2]}};

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   riseOnce_a: assert property (lineRise[0] |=> !lineRise[0])
      else $error("rise pulse lasted more than one cycle");
endmodule : sevirq_line_sync

// ### dv/sevirq_card_model.sv
// Behavioural model of the card lines of both sockets.
`timescale 1ns/1ps
`include "sevirq_regs.svh"
module sevirq_card_model (
   // Clock.
   input  wire logic       core_clk,
   // Card lines, one bit per socket.
   output logic      [1:0] cardDetectA_n,
   output logic      [1:0] cardDetectB_n,
   output logic      [1:0] readyLine,
   output logic      [1:0] batteryLowLine,
   output logic      [1:0] cardEventLine_n,
   output logic      [1:0] ringLine_n
);
   logic [1:0] lineState [`SEVIRQ_LINES];

   // Active-low lines start released, active-high lines start low.
   initial begin
      lineState = '{2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3};
   end

   assign cardDetectA_n   = lineState[`SEVIRQ_LN_DETA];
   assign cardDetectB_n   = lineState[`SEVIRQ_LN_DETB];
   assign readyLine       = lineState[`SEVIRQ_LN_READY];
   assign batteryLowLine  = lineState[`SEVIRQ_LN_BATLOW];
   assign cardEventLine_n = lineState[`SEVIRQ_LN_EVENT];
   assign ringLine_n      = lineState[`SEVIRQ_LN_RING];

   // Lines move after a falling edge so they never race the sampling edge.
   task automatic toggle_line(input int idx, input int sock);
      @(negedge core_clk);
      lineState[idx][sock] = ~lineState[idx][sock];
   endtask : toggle_line
endmodule : sevirq_card_model

// ### dv/test_card_status_change_irq.sv
// Self-checking bench for the socket event flags, masks and routing.
`timescale 1ns/1ps
`include "sevirq_regs.svh"
module test_card_status_change_irq
   import sevirq_pkg::*;
;
   logic        core_clk;
   logic        nrst;
   logic [11:0] regAddr;
   logic        regSocket;
   logic        regRead;
   logic        regWrite;
   logic [7:0]  regWdata;
   logic [7:0]  regRdata;
   logic [1:0]  cardDetectA_n;
   logic [1:0]  cardDetectB_n;
   logic [1:0]  readyLine;
   logic [1:0]  batteryLowLine;
   logic [1:0]  cardEventLine_n;
   logic [1:0]  ringLine_n;
   logic [1:0]  ioCardSelect;
   logic [1:0]  ringFunctionEnable;
   logic [1:0]  eventPciRoute;
   logic [1:0]  clearOnWrite;
   logic        diagSocketEvent;
   logic [15:0] legacyIrq;
   logic        systemMgmtIrq;
   logic        pciIrq;
   int          failures;
   int          samples_checked;

   sevirq_top dut (
      .core_clk, .nrst, .regAddr, .regSocket, .regRead, .regWrite, .regWdata, .regRdata,
      .cardDetectA_n, .cardDetectB_n, .readyLine, .batteryLowLine, .cardEventLine_n,
      .ringLine_n, .ioCardSelect, .ringFunctionEnable, .eventPciRoute, .clearOnWrite,
      .diagSocketEvent, .legacyIrq, .systemMgmtIrq, .pciIrq
   );

   sevirq_card_model card (
      .core_clk, .cardDetectA_n, .cardDetectB_n, .readyLine, .batteryLowLine,
      .cardEventLine_n, .ringLine_n
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      samples_checked++;
      if (seen !== expected) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, expected);
      end
   endtask : check

   task automatic reg_write(input logic [11:0] addr, input logic sock, input logic [7:0] data);
      @(negedge core_clk);
      regAddr = addr;
      regSocket = sock;
      regWdata = data;
      regWrite = 1'b1;
      @(negedge core_clk);
      regWrite = 1'b0;
   endtask : reg_write

   task automatic read_check(input logic [11:0] addr, input logic sock, input logic [7:0] exp);
      @(negedge core_clk);
      regAddr = addr;
      regSocket = sock;
      regRead = 1'b1;
      @(negedge core_clk);
      regRead = 1'b0;
      check({8'h00, regRdata}, {8'h00, exp});
   endtask : read_check

   // An event reaches the outputs four edges after the line moves.
   task automatic settle();
      repeat (6) @(negedge core_clk);
   endtask : settle

   task automatic final_report();
      if (failures == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   initial begin
      #200000;
      failures++;
      final_report();
   end

   initial begin
      failures = 0;
      samples_checked = 0;
      nrst = 1'b0;
      regAddr = 12'h000;
      regSocket = 1'b0;
      regRead = 1'b0;
      regWrite = 1'b0;
      regWdata = 8'h00;
      ioCardSelect = 2'b00;
      ringFunctionEnable = 2'b00;
      eventPciRoute = 2'b00;
      clearOnWrite = 2'b00;
      diagSocketEvent = 1'b0;
      repeat (12) @(negedge core_clk);
      nrst = 1'b1;
      read_check(`SEVIRQ_FLAGS_A, 1'b0, `SEVIRQ_RESET_VAL);
      read_check(`SEVIRQ_MASK_A, 1'b0, `SEVIRQ_RESET_VAL);
      read_check(`SEVIRQ_MASK_B, 1'b0, `SEVIRQ_RESET_VAL);
      reg_write(12'h006, 1'b0, 8'hff);
      read_check(12'h006, 1'b0, 8'h00);
      // A ready rise with its enable off must leave no trace.
      reg_write(`SEVIRQ_MASK_A, 1'b0, 8'h30);
      read_check(`SEVIRQ_MASK_A, 1'b0, 8'h30);
      card.toggle_line(`SEVIRQ_LN_READY, 0);
      settle();
      check(legacyIrq, 16'h0000);
      read_check(`SEVIRQ_FLAGS_A, 1'b0, 8'h00);
      card.toggle_line(`SEVIRQ_LN_READY, 0);
      for (int sel = 1; sel < 16; sel++) begin
         reg_write(`SEVIRQ_MASK_A, 1'b0, {sel[3:0], 4'h8});
         card.toggle_line(sel[0] ? `SEVIRQ_LN_DETA : `SEVIRQ_LN_DETB, 0);
         settle();
         check(legacyIrq, (sel == 2) ? 16'h0000 : 16'h0001 << sel);
         check({15'h0000, systemMgmtIrq}, {15'h0000, sel == 2});
         check({15'h0000, pciIrq}, 16'h0000);
         read_check(`SEVIRQ_FLAGS_A, 1'b0, 8'h08);
         read_check(`SEVIRQ_FLAGS_A, 1'b0, 8'h00);
         repeat (2) @(negedge core_clk);
         check(legacyIrq, 16'h0000);
      end
      // Second socket through the window, cleared by writing one.
      clearOnWrite = 2'b10;
      reg_write(`SEVIRQ_MASK_WIN, 1'b1, 8'h34);
      read_check(`SEVIRQ_MASK_B, 1'b0, 8'h34);
      read_check(`SEVIRQ_MASK_A, 1'b0, 8'hf8);
      card.toggle_line(`SEVIRQ_LN_READY, 1);
      settle();
      check(legacyIrq, 16'h0008);
      eventPciRoute = 2'b10;
      repeat (2) @(negedge core_clk);
      check({15'h0000, pciIrq}, 16'h0001);
      check(legacyIrq, 16'h0000);
      eventPciRoute = 2'b00;
      reg_write(`SEVIRQ_MASK_B, 1'b0, 8'h24);
      repeat (2) @(negedge core_clk);
      check({15'h0000, systemMgmtIrq}, 16'h0001);
      read_check(`SEVIRQ_FLAGS_WIN, 1'b1, 8'h04);
      read_check(`SEVIRQ_FLAGS_B, 1'b0, 8'h04);
      read_check(`SEVIRQ_FLAGS_A, 1'b0, 8'h00);
      reg_write(`SEVIRQ_FLAGS_B, 1'b0, 8'h04);
      read_check(`SEVIRQ_FLAGS_B, 1'b0, 8'h00);
      // Battery sources on a memory card, then on an I/O card.
      reg_write(`SEVIRQ_MASK_A, 1'b0, 8'h37);
      card.toggle_line(`SEVIRQ_LN_BATLOW, 0);
      card.toggle_line(`SEVIRQ_LN_EVENT, 0);
      settle();
      read_check(`SEVIRQ_FLAGS_A, 1'b0, 8'h03);
      card.toggle_line(`SEVIRQ_LN_BATLOW, 0);
      card.toggle_line(`SEVIRQ_LN_EVENT, 0);
      ioCardSelect = 2'b01;
      card.toggle_line(`SEVIRQ_LN_BATLOW, 0);
      card.toggle_line(`SEVIRQ_LN_READY, 0);
      card.toggle_line(`SEVIRQ_LN_EVENT, 0);
      settle();
      read_check(`SEVIRQ_FLAGS_A, 1'b0, 8'h01);
      card.toggle_line(`SEVIRQ_LN_EVENT, 0);
      ioCardSelect = 2'b00;
      // Select field zero: no route, diagnostic route; then the route bit over select field 3.
      reg_write(`SEVIRQ_MASK_A, 1'b0, 8'h08);
      card.toggle_line(`SEVIRQ_LN_DETA, 0);
      settle();
      check({15'h0000, pciIrq}, 16'h0000);
      diagSocketEvent = 1'b1;
      repeat (2) @(negedge core_clk);
      check({15'h0000, pciIrq}, 16'h0001);
      diagSocketEvent = 1'b0;
      eventPciRoute = 2'b01;
      reg_write(`SEVIRQ_MASK_A, 1'b0, 8'h38);
      repeat (2) @(negedge core_clk);
      check({15'h0000, pciIrq}, 16'h0001);
      check(legacyIrq, 16'h0000);
      eventPciRoute = 2'b00;
      repeat (2) @(negedge core_clk);
      check(legacyIrq, 16'h0008);
      read_check(`SEVIRQ_FLAGS_A, 1'b0, 8'h08);
      // Ring level shows in bit 0 only with the ring function on.
      reg_write(`SEVIRQ_MASK_A, 1'b0, 8'h01);
      card.toggle_line(`SEVIRQ_LN_RING, 0);
      settle();
      read_check(`SEVIRQ_FLAGS_A, 1'b0, 8'h00);
      ringFunctionEnable = 2'b01;
      settle();
      read_check(`SEVIRQ_FLAGS_A, 1'b0, 8'h01);
      card.toggle_line(`SEVIRQ_LN_RING, 0);
      settle();
      read_check(`SEVIRQ_FLAGS_A, 1'b0, 8'h00);
      final_report();
   end
endmodule : test_card_status_change_irq
